// [core/pet_top.sv]
// Second pulse, event capture and serial port routing top level.
`timescale 1ns/1ps
`include "pet_defs.svh"
module pet_top #(
  parameter int unsigned TICKS_PER_SEC = `PET_TICKS_PER_SEC,
  parameter int unsigned PULSE_CYCLES = `PET_PULSE_CYCLES
) (
  input wire logic sys_clk_in, // System clock, 25 MHz.
  input wire logic sys_rst_in, // Synchronous reset, active high.
  input wire logic [`PET_ADDR_W-1:0] reg_addr_in, // Register address.
  input wire logic [31:0] reg_wdata_in, // Register write data.
  input wire logic reg_wr_in, // Write strobe.
  input wire logic reg_rd_in, // Read strobe.
  output logic [31:0] reg_rdata_out, // Read data, one cycle later.
  input wire logic survey_done_in, // Self-survey finished.
  input wire logic clock_mode_ok_in, // Over-determined clock mode.
  input wire logic align_in, // Time scale second strobe.
  output logic [1:0] time_scale_out, // Selected time scale.
  output logic second_pulse_p_out, // Second pulse, true line.
  output logic second_pulse_n_out, // Second pulse, inverted line.
  input wire logic event_in, // External event level.
  input wire logic resp_valid_in, // Command response word valid.
  input wire logic [31:0] resp_data_in, // Command response word.
  output logic resp_ready_out, // Response word taken.
  input wire logic sat_valid_in, // Satellite data word valid.
  input wire logic [31:0] sat_data_in, // Satellite data word.
  output logic sat_ready_out, // Satellite word taken.
  input wire logic nmea_valid_in, // NMEA word valid.
  input wire logic [31:0] nmea_data_in, // NMEA word.
  output logic nmea_ready_out, // NMEA word taken.
  output logic port_a_tx_valid_out, // Secondary port word valid.
  output logic [31:0] port_a_tx_data_out, // Secondary port word.
  output pet_pkg::pet_kind_t port_a_tx_kind_out, // Secondary word kind.
  input wire logic port_a_tx_ready_in, // Secondary port takes word.
  output logic port_b_tx_valid_out, // Primary port word valid.
  output logic [31:0] port_b_tx_data_out, // Primary port word.
  output pet_pkg::pet_kind_t port_b_tx_kind_out, // Primary word kind.
  input wire logic port_b_tx_ready_in, // Primary port takes word.
  input wire logic port_a_rx_valid_in, // Secondary port byte in.
  input wire logic [7:0] port_a_rx_data_in, // Secondary port byte.
  input wire logic port_b_rx_valid_in, // Primary port byte in.
  input wire logic [7:0] port_b_rx_data_in, // Primary port byte.
  output logic cmd_valid_out, // Command byte valid.
  output logic [7:0] cmd_data_out, // Command byte.
  output logic cmd_port_out // Command came from secondary port.
);
  import pet_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Control and status registers.

  logic [`PET_CTRL_W-1:0] ctrl;
  logic even_sel;
  logic tim_en;
  logic sat_en;
  logic tim_on_a;
  logic evt_en;
  logic nmea_a;
  logic nmea_b;
  logic pulse;
  logic pulse_q;
  logic ev_valid;
  logic [31:0] ev_count;
  logic [31:0] ev_sec;
  logic [`PET_SUB_W-1:0] ev_sub;
  logic evt_pend;
  logic tim_pend;
  logic [31:0] tim_sec;
  pet_seq_t seq;
  pet_tb_if tb ();

  // Control word; binary protocol on both ports after reset.
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
      ctrl <= `PET_CTRL_RST;
    else if (reg_wr_in && reg_addr_in == `PET_REG_CTRL)
      ctrl <= reg_wdata_in[`PET_CTRL_W-1:0];
  end

  // Field views of the control word.
  assign even_sel = ctrl[`PET_CTRL_EVEN];
  assign tim_en = ctrl[`PET_CTRL_TIM_EN];
  assign sat_en = ctrl[`PET_CTRL_SAT_EN];
  assign tim_on_a = ctrl[`PET_CTRL_TIM_ON_A];
  assign evt_en = ctrl[`PET_CTRL_EVT_EN];
  assign nmea_a = ctrl[`PET_CTRL_NMEA_A];
  assign nmea_b = ctrl[`PET_CTRL_NMEA_B];
  assign time_scale_out = ctrl[`PET_CTRL_SCALE_HI:`PET_CTRL_SCALE_LO];

  // Read data stand for as many cycles as the read strobe; unmapped reads give zero.
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in || !reg_rd_in)
      reg_rdata_out <= 32'h0;
    else
    begin
      unique case (reg_addr_in)
        `PET_REG_CTRL: reg_rdata_out <= 32'(ctrl);
        `PET_REG_STATUS: reg_rdata_out <= {27'h0, seq != pet_s_idle,
          evt_pend, pulse, clock_mode_ok_in, survey_done_in};
        `PET_REG_SEC: reg_rdata_out <= tb.sec;
        `PET_REG_EVT_CNT: reg_rdata_out <= ev_count;
        `PET_REG_EVT_SEC: reg_rdata_out <= ev_sec;
        `PET_REG_EVT_SUB: reg_rdata_out <= 32'(ev_sub);
        default: reg_rdata_out <= 32'h0;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Second pulse and event capture.

  pet_pulse_gen #(
    .TICKS_PER_SEC(TICKS_PER_SEC),
    .PULSE_CYCLES(PULSE_CYCLES)
  ) u_pulse (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .align_in(align_in),
    .en_in(clock_mode_ok_in),
    .even_in(even_sel),
    .tb(tb.gen),
    .pulse_out(pulse)
  );

  // Differential pair; the inverted line idles high.
  assign second_pulse_p_out = pulse;
  assign second_pulse_n_out = ~pulse;

  pet_event_cap u_event (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .event_in(event_in),
    .enable_in(evt_en),
    .tb(tb.cap),
    .valid_out(ev_valid),
    .count_out(ev_count),
    .sec_out(ev_sec),
    .sub_out(ev_sub)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Report sequencer: event reports and timing reports.

  logic rep_valid;
  logic rep_ready;
  logic [31:0] rep_data;
  pet_kind_t rep_kind;
  logic take_evt;
  logic take_tim;

  assign take_evt = (seq == pet_s_idle) && evt_pend;
  assign take_tim = (seq == pet_s_idle) && !evt_pend && tim_pend;

  // Pending flags; a new request wins over its own clear.
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      pulse_q <= 1'b0;
      evt_pend <= 1'b0;
      tim_pend <= 1'b0;
      tim_sec <= 32'h0;
    end
    else
    begin
      pulse_q <= pulse;
      evt_pend <= ev_valid || (evt_pend && !take_evt);
      if (pulse && !pulse_q && survey_done_in && tim_en)
      begin
        tim_pend <= 1'b1;
        tim_sec <= tb.sec;
      end
      else if (take_tim)
        tim_pend <= 1'b0;
    end
  end

  // One report at a time; words advance as the chosen port takes them.
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
      seq <= pet_s_idle;
    else
    begin
      unique case (seq)
        pet_s_idle:
          if (take_evt)
            seq <= pet_s_evt0;
          else if (take_tim)
            seq <= pet_s_tim;
        pet_s_evt0:
          if (rep_ready)
            seq <= pet_s_evt1;
        pet_s_evt1:
          if (rep_ready)
            seq <= pet_s_evt2;
        pet_s_evt2:
          if (rep_ready)
            seq <= pet_s_idle;
        pet_s_tim:
          if (rep_ready)
            seq <= pet_s_idle;
        default:
          seq <= pet_s_idle;
      endcase
    end
  end

  // Report word for the current step.
  always_comb
  begin
    rep_valid = (seq != pet_s_idle);
    rep_kind = pet_k_event;
    rep_data = 32'h0;
    unique case (seq)
      pet_s_evt0: rep_data = ev_count;
      pet_s_evt1: rep_data = ev_sec;
      pet_s_evt2: rep_data = 32'(ev_sub);
      pet_s_tim:
      begin
        rep_kind = pet_k_timing;
        rep_data = tim_sec;
      end
      default: rep_data = 32'h0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transmit routing. Sources: 0 response, 1 satellite, 2 NMEA, 3 report.

  logic [3:0] src_valid;
  logic [3:0] src_ready;
  logic [31:0] src_data [4];
  pet_kind_t src_kind [4];
  logic [3:0] allow [2];
  logic [3:0] req [2];
  logic [1:0] sel [2];
  logic load [2];
  logic tx_valid [2];
  logic tx_ready [2];
  logic [31:0] tx_data [2];
  pet_kind_t tx_kind [2];
  logic rep_to_a;

  // Reports ahead of responses, then satellite data, then NMEA.
  function automatic logic [1:0] pet_pick(input logic [3:0] r);
    if (r[3])
      pet_pick = 2'h3;
    else if (r[0])
      pet_pick = 2'h0;
    else if (r[1])
      pet_pick = 2'h1;
    else
      pet_pick = 2'h2;
  endfunction : pet_pick

  assign src_valid = {rep_valid, nmea_valid_in, sat_valid_in, resp_valid_in};
  assign src_data[0] = resp_data_in;
  assign src_data[1] = sat_data_in;
  assign src_data[2] = nmea_data_in;
  assign src_data[3] = rep_data;
  assign src_kind[0] = pet_k_resp;
  assign src_kind[1] = pet_k_sat;
  assign src_kind[2] = pet_k_nmea;
  assign src_kind[3] = rep_kind;

  // Secondary port carries reports or NMEA only, never responses.
  assign rep_to_a = tim_on_a && !nmea_a;
  assign allow[0] = {rep_to_a, nmea_a, 2'b00};
  // Primary port: binary traffic, or NMEA alone when so configured.
  assign allow[1] = {!rep_to_a && !nmea_b, !nmea_a && nmea_b,
    sat_en && !nmea_b, !nmea_b};

  assign tx_ready[0] = port_a_tx_ready_in;
  assign tx_ready[1] = port_b_tx_ready_in;

  // One output word register per port.
  for (genvar p = 0; p < 2; p++)
  begin : g_port
    assign req[p] = src_valid & allow[p];
    assign sel[p] = pet_pick(req[p]);
    assign load[p] = (|req[p]) && (!tx_valid[p] || tx_ready[p]);
    always_ff @(posedge sys_clk_in)
    begin
      if (sys_rst_in)
      begin
        tx_valid[p] <= 1'b0;
        tx_data[p] <= 32'h0;
        tx_kind[p] <= pet_k_resp;
      end
      else if (load[p])
      begin
        tx_valid[p] <= 1'b1;
        tx_data[p] <= src_data[sel[p]];
        tx_kind[p] <= src_kind[sel[p]];
      end
      else if (tx_ready[p])
        tx_valid[p] <= 1'b0;
    end
  end

  // A source no port may carry is drained so it never stalls upstream.
  always_comb
  begin
    for (int s = 0; s < 4; s++)
    begin
      src_ready[s] = !(allow[0][s] || allow[1][s]);
      for (int p = 0; p < 2; p++)
        if (load[p] && sel[p] == 2'(s))
          src_ready[s] = 1'b1;
    end
  end

  assign resp_ready_out = src_ready[0];
  assign sat_ready_out = src_ready[1];
  assign nmea_ready_out = src_ready[2];
  assign rep_ready = src_ready[3];
  assign port_a_tx_valid_out = tx_valid[0];
  assign port_a_tx_data_out = tx_data[0];
  assign port_a_tx_kind_out = tx_kind[0];
  assign port_b_tx_valid_out = tx_valid[1];
  assign port_b_tx_data_out = tx_data[1];
  assign port_b_tx_kind_out = tx_kind[1];

  //////////////////////////////////////////////////////////////////////////////
  // Command receive. NMEA ports take no input; events close port A.

  logic rx_en_a;
  logic rx_en_b;
  assign rx_en_a = !nmea_a && !evt_en;
  assign rx_en_b = !nmea_b;

  // Primary port wins when both deliver a byte in one cycle.
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      cmd_valid_out <= 1'b0;
      cmd_data_out <= 8'h00;
      cmd_port_out <= 1'b0;
    end
    else
    begin
      cmd_valid_out <= (port_b_rx_valid_in && rx_en_b) ||
        (port_a_rx_valid_in && rx_en_a);
      if (port_b_rx_valid_in && rx_en_b)
      begin
        cmd_data_out <= port_b_rx_data_in;
        cmd_port_out <= 1'b0;
      end
      else if (port_a_rx_valid_in && rx_en_a)
      begin
        cmd_data_out <= port_a_rx_data_in;
        cmd_port_out <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_evt_word;
    seq == pet_s_evt0 && rep_ready;
  endsequence
  property p_evt_seq;
    s_evt_word |=> seq == pet_s_evt1 ##0 rep_data == ev_sec;
  endproperty
  a_evt_seq: assert property (p_evt_seq) else $error("event walk");
  property p_evt_pend;
    ev_valid |=> evt_pend || seq == pet_s_evt0;
  endproperty
  a_evt_pend: assert property (p_evt_pend) else $error("event lost");
  property p_rx_a;
    port_a_rx_valid_in && evt_en && !port_b_rx_valid_in |=> !cmd_valid_out;
  endproperty
  a_rx_a: assert property (p_rx_a) else $error("rx while event on");
  property p_nmea_b;
    load[1] && nmea_b |=> port_b_tx_kind_out == pet_k_nmea;
  endproperty
  a_nmea_b: assert property (p_nmea_b) else $error("binary on NMEA port");
  property p_tim_rep;
    $rose(pulse) && survey_done_in && tim_en |=> tim_pend;
  endproperty
  a_tim_rep: assert property (p_tim_rep) else $error("timing report lost");
  property p_rd;
    reg_rd_in && reg_addr_in == `PET_REG_SEC |=> reg_rdata_out == $past(tb.sec);
  endproperty
  a_rd: assert property (p_rd) else $error("seconds read wrong");
endmodule : pet_top

// [common/pet_defs.svh]
// Offsets, field positions, reset values and timing counts.
`ifndef PET_DEFS_SVH
`define PET_DEFS_SVH
`define PET_CLK_PERIOD_NS 40
`define PET_SEC_NS 1000000000
`define PET_PULSE_WIDTH_NS 10000000
`define PET_EVT_LATCH_MAX_NS 500
`define PET_TICKS_PER_SEC (`PET_SEC_NS / `PET_CLK_PERIOD_NS)
`define PET_PULSE_CYCLES (`PET_PULSE_WIDTH_NS / `PET_CLK_PERIOD_NS)
`define PET_EVT_LATCH_MAX_CYC (`PET_EVT_LATCH_MAX_NS / `PET_CLK_PERIOD_NS)
`define PET_SUB_W 25
`define PET_ADDR_W 8
`define PET_REG_CTRL 8'h00
`define PET_REG_STATUS 8'h04
`define PET_REG_SEC 8'h08
`define PET_REG_EVT_CNT 8'h0c
`define PET_REG_EVT_SEC 8'h10
`define PET_REG_EVT_SUB 8'h14
`define PET_CTRL_W 9
`define PET_CTRL_RST 9'h016
`define PET_CTRL_EVEN 0
`define PET_CTRL_TIM_EN 1
`define PET_CTRL_SAT_EN 2
`define PET_CTRL_TIM_ON_A 3
`define PET_CTRL_EVT_EN 4
`define PET_CTRL_NMEA_A 5
`define PET_CTRL_NMEA_B 6
`define PET_CTRL_SCALE_LO 7
`define PET_CTRL_SCALE_HI 8
`endif

// [common/pet_pkg.sv]
// Types shared by the second pulse and event timing block.
package pet_pkg;
  typedef enum logic [2:0] {
    pet_k_resp = 3'h0,
    pet_k_sat = 3'h1,
    pet_k_nmea = 3'h2,
    pet_k_timing = 3'h3,
    pet_k_event = 3'h4
  } pet_kind_t;
  typedef enum logic [2:0] {
    pet_s_idle = 3'h0,
    pet_s_evt0 = 3'h1,
    pet_s_evt1 = 3'h3,
    pet_s_evt2 = 3'h2,
    pet_s_tim = 3'h6
  } pet_seq_t;
endpackage : pet_pkg

// [common/pet_tb_if.sv]
// Timebase carried from the pulse generator to its readers.
`timescale 1ns/1ps
`include "pet_defs.svh"
interface pet_tb_if;
  logic [`PET_SUB_W-1:0] sub;
  logic [31:0] sec;
  logic tick;
  modport gen (output sub, output sec, output tick);
  modport cap (input sub, input sec, input tick);
endinterface : pet_tb_if

// [core/pet_pulse_gen.sv]
// Free-running timebase and the once-per-second pulse.
`timescale 1ns/1ps
`include "pet_defs.svh"
module pet_pulse_gen #(
  parameter int unsigned TICKS_PER_SEC = `PET_TICKS_PER_SEC,
  parameter int unsigned PULSE_CYCLES = `PET_PULSE_CYCLES
) (
  input wire logic sys_clk_in, // System clock.
  input wire logic sys_rst_in, // Synchronous reset.
  input wire logic align_in, // Time scale second boundary strobe.
  input wire logic en_in, // Clock mode allows pulses.
  input wire logic even_in, // Even seconds only.
  pet_tb_if.gen tb, // Timebase out.
  output logic pulse_out // Second pulse level.
);
  import pet_pkg::*;
  localparam logic [`PET_SUB_W-1:0] LAST = `PET_SUB_W'(TICKS_PER_SEC - 1);
  localparam logic [`PET_SUB_W-1:0] WLAST = `PET_SUB_W'(PULSE_CYCLES - 1);
  logic [`PET_SUB_W-1:0] width_cnt;
  logic [`PET_SUB_W-1:0] hi_cnt;
  // A new second starts after the last tick or on an alignment strobe.
  assign tb.tick = align_in || (tb.sub == LAST);
  // Sub-second and second counters.
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in || tb.tick)
      tb.sub <= '0;
    else
      tb.sub <= tb.sub + 1'b1;
    if (sys_rst_in)
      tb.sec <= 32'h0;
    else if (tb.tick)
      tb.sec <= tb.sec + 32'h1;
  end
  // Leading edge on the second boundary, held for the pulse width.
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      pulse_out <= 1'b0;
      width_cnt <= '0;
    end
    else if (tb.tick && en_in && (!even_in || tb.sec[0]))
    begin
      pulse_out <= 1'b1;
      width_cnt <= WLAST;
    end
    else if (width_cnt != '0)
      width_cnt <= width_cnt - 1'b1;
    else
      pulse_out <= 1'b0;
  end
  // Length of the current high phase, for checking only.
  always_ff @(posedge sys_clk_in)
    hi_cnt <= (sys_rst_in || !pulse_out) ? '0 : hi_cnt + 1'b1;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_rise;
    $rose(pulse_out);
  endsequence
  property p_width;
    $fell(pulse_out) && !$past(tb.tick) |-> hi_cnt == WLAST + 1'b1;
  endproperty
  a_width: assert property (p_width) else $error("pulse width wrong");
  property p_lead;
    s_rise |-> tb.sub == '0 && $past(tb.tick);
  endproperty
  a_lead: assert property (p_lead) else $error("pulse off boundary");
  property p_mode;
    s_rise |-> $past(en_in);
  endproperty
  a_mode: assert property (p_mode) else $error("pulse while unlocked");
  property p_even;
    s_rise ##0 $past(even_in) |-> !tb.sec[0];
  endproperty
  a_even: assert property (p_even) else $error("pulse on odd second");
endmodule : pet_pulse_gen

// [core/pet_event_cap.sv]
// Event input synchroniser, edge detector, timestamp and counter.
`timescale 1ns/1ps
`include "pet_defs.svh"
module pet_event_cap (
  input wire logic sys_clk_in, // System clock.
  input wire logic sys_rst_in, // Synchronous reset.
  input wire logic event_in, // External event level.
  input wire logic enable_in, // Event capture enabled.
  pet_tb_if.cap tb, // Timebase in.
  output logic valid_out, // One-cycle capture pulse.
  output logic [31:0] count_out, // Events so far.
  output logic [31:0] sec_out, // Captured seconds.
  output logic [`PET_SUB_W-1:0] sub_out // Captured sub-second ticks.
);
  import pet_pkg::*;
  localparam int LAT_MAX = `PET_EVT_LATCH_MAX_CYC;
  logic sync1;
  logic sync2;
  logic sync3;
  logic rise;
  // Two-stage synchroniser, then a delayed copy for the edge.
  always_ff @(posedge sys_clk_in)
  begin
    sync1 <= sys_rst_in ? 1'b0 : event_in;
    sync2 <= sys_rst_in ? 1'b0 : sync1;
    sync3 <= sys_rst_in ? 1'b0 : sync2;
  end
  assign rise = sync2 && !sync3 && enable_in;
  // Timestamp and count are caught on the detected edge.
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      valid_out <= 1'b0;
      count_out <= 32'h0;
      sec_out <= 32'h0;
      sub_out <= '0;
    end
    else
    begin
      valid_out <= rise;
      if (rise)
      begin
        count_out <= count_out + 32'h1;
        sec_out <= tb.sec;
        sub_out <= tb.sub;
      end
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_evt;
    $rose(event_in) && enable_in ##1 enable_in[*3];
  endsequence
  property p_lat;
    s_evt |-> ##[0:LAT_MAX] valid_out;
  endproperty
  a_lat: assert property (p_lat) else $error("event latched late");
  property p_cnt;
    valid_out |-> count_out == $past(count_out) + 32'h1;
  endproperty
  a_cnt: assert property (p_cnt) else $error("event count wrong");
  property p_stamp;
    valid_out |-> sec_out == $past(tb.sec) && sub_out == $past(tb.sub);
  endproperty
  a_stamp: assert property (p_stamp) else $error("stamp wrong");
endmodule : pet_event_cap

// [testbench/pet_host_model.sv]
// Host model that takes port words and counts second pulse edges.
`timescale 1ns/1ps
module pet_host_model
  import pet_pkg::*;
(
  input wire logic sys_clk_in, // Clock.
  input wire logic sys_rst_in, // Reset.
  input wire logic slow_in, // Take words every other cycle.
  input wire logic a_valid_in, // Port A word valid.
  input wire pet_pkg::pet_kind_t a_kind_in, // Port A kind.
  output logic a_ready_out, // Port A ready.
  input wire logic b_valid_in, // Port B word valid.
  input wire logic [31:0] b_data_in, // Port B word.
  input wire pet_pkg::pet_kind_t b_kind_in, // Port B kind.
  output logic b_ready_out, // Port B ready.
  input wire logic pulse_in // Second pulse, true line.
);
  logic phase;
  logic pulse_q;
  logic [31:0] na;
  logic [31:0] nb;
  logic [31:0] pulses;
  logic [31:0] b_data;
  pet_kind_t a_kind;
  pet_kind_t b_kind;
  // A slow host is ready only on alternate cycles.
  assign a_ready_out = !slow_in || phase;
  assign b_ready_out = !slow_in || phase;
  // Words are logged as taken; time comes from the rising edge alone.
  always_ff @(posedge sys_clk_in)
  begin
    phase <= !phase && !sys_rst_in;
    pulse_q <= pulse_in;
    if (sys_rst_in)
    begin
      na <= 32'h0;
      nb <= 32'h0;
      pulses <= 32'h0;
    end
    else
    begin
      if (pulse_in && !pulse_q)
        pulses <= pulses + 32'h1;
      if (a_valid_in && a_ready_out)
      begin
        na <= na + 32'h1;
        a_kind <= a_kind_in;
      end
      if (b_valid_in && b_ready_out)
      begin
        nb <= nb + 32'h1;
        b_kind <= b_kind_in;
        b_data <= b_data_in;
      end
    end
  end
endmodule : pet_host_model

// [testbench/pet_top_tb_top.sv]
// Self-checking bench for the second pulse and event timing top.
`timescale 1ns/1ps
`include "pet_defs.svh"
module pet_top_tb_top;
  import pet_pkg::*;
  localparam int T = 200;
  localparam int W = 20;
  logic sys_clk_in = '0, sys_rst_in = '1, reg_wr_in = '0, reg_rd_in = '0;
  logic survey_done_in = '0, clock_mode_ok_in = '0, align_in = '0;
  logic event_in = '0, resp_valid_in = '0, sat_valid_in = '0, slow = '0;
  logic nmea_valid_in = '0, port_a_rx_valid_in = '0;
  logic port_b_rx_valid_in = '0, port_a_tx_ready_in, port_b_tx_ready_in;
  logic [7:0] reg_addr_in = '0, port_a_rx_data_in = '0, cmd_data_out;
  logic [7:0] port_b_rx_data_in = '0;
  logic [31:0] reg_wdata_in = '0, resp_data_in = '0, sat_data_in = '0;
  logic [31:0] nmea_data_in = '0, reg_rdata_out, v;
  logic [31:0] port_a_tx_data_out, port_b_tx_data_out;
  logic [1:0] time_scale_out;
  logic second_pulse_p_out, second_pulse_n_out, resp_ready_out;
  logic sat_ready_out, nmea_ready_out, port_a_tx_valid_out;
  logic port_b_tx_valid_out, cmd_valid_out, cmd_port_out;
  pet_kind_t port_a_tx_kind_out, port_b_tx_kind_out;
  int fails = 0, comparisons = 0, c, w, n;
  pet_top #(.TICKS_PER_SEC(T), .PULSE_CYCLES(W)) DUT (.*);
  pet_host_model host (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
    .slow_in(slow), .a_valid_in(port_a_tx_valid_out),
    .a_kind_in(port_a_tx_kind_out), .a_ready_out(port_a_tx_ready_in),
    .b_valid_in(port_b_tx_valid_out), .b_data_in(port_b_tx_data_out),
    .b_kind_in(port_b_tx_kind_out), .b_ready_out(port_b_tx_ready_in),
    .pulse_in(second_pulse_p_out));
  // Free-running system clock.
  always #20 sys_clk_in = ~sys_clk_in;
  task check(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      fails++;
    end
  endtask : check
  task summarize;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize
  task tick(input int k);
    repeat (k) @(posedge sys_clk_in);
  endtask : tick
  task step;
    @(posedge sys_clk_in);
    #1 c++;
  endtask : step
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= '1;
    @(posedge sys_clk_in);
    reg_wr_in <= '0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= '1;
    @(posedge sys_clk_in);
    reg_rd_in <= '0;
    #1 v = reg_rdata_out;
  endtask : rd
  task rise;
    c = 0;
    while (second_pulse_p_out === 1'h1 && c < 2000)
      step();
    while (second_pulse_p_out !== 1'h1 && c < 2000)
      step();
    check("rise", 32'(c < 2000), 32'h1);
  endtask : rise
  task evt;
    @(posedge sys_clk_in);
    event_in <= '1;
    tick(4);
    event_in <= '0;
  endtask : evt
  task rxb(input logic a, input logic [7:0] d);
    @(posedge sys_clk_in);
    port_a_rx_valid_in <= a;
    port_b_rx_valid_in <= !a;
    port_a_rx_data_in <= d;
    port_b_rx_data_in <= d;
    @(posedge sys_clk_in);
    port_a_rx_valid_in <= '0;
    port_b_rx_valid_in <= '0;
    #1 v = 32'({cmd_port_out, cmd_valid_out, cmd_data_out});
  endtask : rxb
  task t_reg;
    rd(`PET_REG_CTRL);
    check("ctrl", v, 32'h16);
    rd(8'h3c);
    check("unmapped", v, 32'h0);
    wr(`PET_REG_CTRL, 32'h196);
    tick(2);
    check("scale", 32'(time_scale_out), 32'h3);
    $display("reg done");
  endtask : t_reg
  task t_pulse;
    wr(`PET_REG_CTRL, 32'h16);
    rise();
    check("n low", 32'(second_pulse_n_out), 32'h0);
    w = 0;
    while (second_pulse_p_out === 1'h1 && w < 300)
    begin
      @(posedge sys_clk_in);
      #1 w++;
    end
    check("width", w, W);
    check("n line", 32'(second_pulse_n_out), 32'h1);
    n = host.nb;
    rise();
    check("period", c + w, T);
    tick(6);
    check("report", host.nb, n + 1);
    check("kind", 32'(host.b_kind), 32'(pet_k_timing));
    tick(W);
    align_in <= '1;
    tick(1);
    align_in <= '0;
    #1 check("align", 32'(second_pulse_p_out), 32'h1);
    $display("pulse done");
  endtask : t_pulse
  task t_mode;
    wr(`PET_REG_CTRL, 32'h15);
    rise();
    rise();
    check("even period", c, 2 * T);
    rd(`PET_REG_SEC);
    check("even sec", v[0], 1'h0);
    @(posedge sys_clk_in);
    clock_mode_ok_in <= '0;
    n = host.pulses;
    tick(450);
    check("no pulse", host.pulses, n);
    clock_mode_ok_in <= '1;
    $display("mode done");
  endtask : t_mode
  task t_event;
    wr(`PET_REG_CTRL, 32'h14);
    rise();
    n = host.nb;
    evt();
    tick(12);
    rd(`PET_REG_EVT_CNT);
    check("count 1", v, 32'h1);
    check("words b", host.nb, n + 3);
    check("kind b", 32'(host.b_kind), 32'(pet_k_event));
    rd(`PET_REG_EVT_SUB);
    check("stamp", 32'(v < 32'he), 32'h1);
    wr(`PET_REG_CTRL, 32'h1c);
    slow <= '1;
    rise();
    n = host.nb;
    w = host.na;
    evt();
    tick(20);
    check("words a", host.na, w + 3);
    check("b quiet", host.nb, n);
    check("kind a", 32'(host.a_kind), 32'(pet_k_event));
    rd(`PET_REG_EVT_CNT);
    check("count 2", v, 32'h2);
    slow <= '0;
    $display("event done");
  endtask : t_event
  task t_port;
    wr(`PET_REG_CTRL, 32'h10);
    n = host.nb;
    sat_valid_in <= '1;
    sat_data_in <= 32'h5a5a0001;
    tick(6);
    check("sat drop", 32'(sat_ready_out), 32'h1);
    sat_valid_in <= '0;
    check("sat off", host.nb, n);
    resp_valid_in <= '1;
    resp_data_in <= 32'hc0de0002;
    c = 0;
    do @(negedge sys_clk_in); while (resp_ready_out !== 1'h1 && ++c < 50);
    @(posedge sys_clk_in);
    resp_valid_in <= '0;
    tick(4);
    check("resp n", host.nb, n + 1);
    check("resp kind", 32'(host.b_kind), 32'(pet_k_resp));
    check("resp data", host.b_data, 32'hc0de0002);
    wr(`PET_REG_CTRL, 32'h40);
    nmea_valid_in <= '1;
    nmea_data_in <= 32'h0e0a0003;
    @(negedge sys_clk_in);
    check("nmea rdy", 32'(nmea_ready_out), 32'h1);
    @(posedge sys_clk_in);
    nmea_valid_in <= '0;
    tick(4);
    check("nmea n", host.nb, n + 2);
    check("nmea kind", 32'(host.b_kind), 32'(pet_k_nmea));
    check("nmea data", host.b_data, 32'h0e0a0003);
    wr(`PET_REG_CTRL, 32'h10);
    $display("port done");
  endtask : t_port
  task t_rx;
    rxb(1'h1, 8'h3c);
    check("a blocked", v[8], 1'h0);
    rxb(1'h0, 8'ha5);
    check("b cmd", v, 32'h1a5);
    wr(`PET_REG_CTRL, 32'h0);
    rxb(1'h1, 8'h3c);
    check("a cmd", v, 32'h33c);
    $display("rx done");
  endtask : t_rx
  // Reset, then the scenarios in turn.
  initial
  begin
    tick(12);
    sys_rst_in <= '0;
    survey_done_in <= '1;
    clock_mode_ok_in <= '1;
    t_reg();
    t_pulse();
    t_mode();
    t_event();
    t_port();
    t_rx();
    summarize();
  end
  // Watchdog cuts a hang short.
  initial
  begin
    #(40 * 20000);
    fails++;
    summarize();
  end
endmodule : pet_top_tb_top
